// >>> error_queue_pkg.sv
package error_queue_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int QUEUE_DEPTH = 30;
	localparam int ORD_SLOTS   = 29;
	localparam int CODE_W      = 16;
	localparam int ADR_W       = 8;
	localparam int DATA_W      = 32;

	//////////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses, one word each)
	localparam logic [ADR_W-1:0] OFS_POP     = 8'h00;
	localparam logic [ADR_W-1:0] OFS_LEVEL   = 8'h04;
	localparam logic [ADR_W-1:0] OFS_EVENT   = 8'h08;
	localparam logic [ADR_W-1:0] OFS_CONTROL = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_REPORT  = 8'h10;

	//////////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int ESR_CMD_BIT    = 5;
	localparam int ESR_EXEC_BIT   = 4;
	localparam int ESR_DEV_BIT    = 3;
	localparam int ESR_QUERY_BIT  = 2;
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int LEVEL_MARK_BIT = 8;
	localparam logic [7:0] ESR_RESET = 8'h00;

	//////////////////////////////////////////////////////////////////////////////
	// error codes, two's complement
	localparam logic [CODE_W-1:0] CODE_NONE      = 16'h0000; // 0
	localparam logic [CODE_W-1:0] CODE_CMD_GEN   = 16'hFF9C; // -100
	localparam logic [CODE_W-1:0] CODE_CMD_LAST  = 16'hFF39; // -199
	localparam logic [CODE_W-1:0] CODE_GET_MSG   = 16'hFF97; // -105
	localparam logic [CODE_W-1:0] CODE_HDR_UNDEF = 16'hFF8F; // -113
	localparam logic [CODE_W-1:0] CODE_EXE_GEN   = 16'hFF38; // -200
	localparam logic [CODE_W-1:0] CODE_EXE_LAST  = 16'hFED5; // -299
	localparam logic [CODE_W-1:0] CODE_DEV_GEN   = 16'hFED4; // -300
	localparam logic [CODE_W-1:0] CODE_SELFTEST  = 16'hFEB6; // -330
	localparam logic [CODE_W-1:0] CODE_OVERFLOW  = 16'hFEA2; // -350
	localparam logic [CODE_W-1:0] CODE_DEV_LAST  = 16'hFE71; // -399
	localparam logic [CODE_W-1:0] CODE_QRY_GEN   = 16'hFE70; // -400
	localparam logic [CODE_W-1:0] CODE_QRY_LAST  = 16'hFE0D; // -499
	localparam logic [CODE_W-1:0] CODE_POS_LAST  = 16'h7FFF; // +32767

	typedef enum {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage

// >>> queue_if.sv
`timescale 1ns/100ps
interface queue_if #(
	parameter int W  = 16,
	parameter int CW = 5
);
	logic         push;
	logic [W-1:0] push_data;
	logic         pop;
	logic         clear;
	logic [W-1:0] head;
	logic [CW-1:0] count;

	modport store
	(
		input  push,
		input  push_data,
		input  pop,
		input  clear,
		output head,
		output count
	);

	modport ctrl
	(
		output push,
		output push_data,
		output pop,
		output clear,
		input  head,
		input  count
	);
endinterface

// >>> queue_store.sv
`timescale 1ns/100ps
module queue_store #(
	parameter int DEPTH = 30,
	parameter int W     = 16
)(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// queue side
	queue_if.store    q
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	if (DEPTH < 2)
	begin : depth_check
		$error("queue_store: DEPTH must be at least 2");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] rd_ptr_reg;
	logic [PW-1:0] wr_ptr_reg;
	logic [CW-1:0] count_reg;

	wire           do_pop  = q.pop & (count_reg != '0) & ~q.clear;
	wire           do_push = q.push & (q.clear | do_pop | (count_reg != FULL_CNT));
	wire [PW-1:0]  wr_addr = q.clear ? '0 : wr_ptr_reg;
	wire [PW-1:0]  rd_inc  = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
	wire [PW-1:0]  wr_inc  = (wr_addr == LAST_PTR) ? '0 : wr_addr + 1'b1;
	wire [CW-1:0]  base    = q.clear ? '0 : count_reg;
	wire [CW-1:0]  count_next = base + CW'(do_push) - CW'(do_pop);

	assign q.head  = mem[rd_ptr_reg];
	assign q.count = count_reg;

	// head read and tail write on separate pointers keep strict arrival order
	always_ff @(posedge ref_clk)
	begin
		if (do_push)
			mem[wr_addr] <= q.push_data; // R02
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			rd_ptr_reg <= q.clear ? '0 : (do_pop ? rd_inc : rd_ptr_reg); // R05
			wr_ptr_reg <= do_push ? wr_inc : wr_addr;
			count_reg  <= count_next; // R20
		end
	end

	fifo_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R02
		(q.push & ~q.pop & ~q.clear & (count_reg == '0)) |=> (q.head == $past(q.push_data)))
		else $error("first stored code is not at the head");
	pop_frees_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R05
		(do_pop & ~q.push) |=> (count_reg == $past(count_reg) - 1'b1))
		else $error("pop did not free a slot");
endmodule

// >>> error_code_queue.sv
// What this block does
// R01: pop read returns and removes oldest code
// R02: codes leave in strict arrival order
// R03: thirty entries, twenty-nine ordinary, one marker
// R04: full queue drops newest, writes minus 350
// R05: popping head frees a slot at tail
// R06: empty queue pops answer zero, state unchanged
// R07: cleared at power-on, clear command, last pop
// R08: each recorded error sets its class bit
// R09: classes decoded from the code's numeric range
// R10: first code of class is the generic code
// R11: command errors set event status bit 5
// R12: command error suppresses other classes same event
// R13: unknown header reported as command error
// R14: trigger inside message reported as command error
// R15: execution errors set event status bit 4
// R16: execution check follows rounding, rounding no error
// R17: device-specific errors set event status bit 3
// R18: query errors set event status bit 2
// R19: recorded error code shown on display
// R20: same-cycle push and pop keep count exact
`timescale 1ns/100ps
module error_code_queue
	import error_queue_pkg::*;
#(
	parameter int DEPTH = error_queue_pkg::QUEUE_DEPTH
)(
	// clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               sys_rst,
	// wishbone slave
	input  wire logic                               wb_cyc_i,
	input  wire logic                               wb_stb_i,
	input  wire logic                               wb_we_i,
	input  wire logic [error_queue_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                         wb_sel_i,
	input  wire logic [error_queue_pkg::DATA_W-1:0] wb_dat_i,
	output logic      [error_queue_pkg::DATA_W-1:0] wb_dat_o,
	output logic                                    wb_ack_o,
	// error sources
	input  wire logic                               err_valid,
	input  wire logic [error_queue_pkg::CODE_W-1:0] err_code,
	input  wire logic                               hdr_unknown,
	input  wire logic                               get_in_msg,
	input  wire logic                               exec_param_invalid,
	input  wire logic                               selftest_fail,
	input  wire logic                               out_read_empty,
	input  wire logic                               out_data_lost,
	// display
	input  wire logic                               single_measurement_setting,
	input  wire logic                               meas_result_shown,
	output logic      [error_queue_pkg::CODE_W-1:0] disp_code,
	output logic                                    disp_show,
	// status
	output logic      [7:0]                         event_status,
	output logic      [$clog2(DEPTH+1)-1:0]         queue_count
);
	import error_queue_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] ORD_CNT = CW'(ORD_SLOTS);

	// refuse a depth that leaves no room for exactly one marker slot
	if (DEPTH != ORD_SLOTS + 1)
	begin : depth_check
		$error("error_code_queue: DEPTH must be one more than the ordinary slots");
	end

	//////////////////////////////////////////////////////////////////////////////
	// class decode
	function automatic logic [7:0] class_bits(input logic [CODE_W-1:0] c);
		logic signed [CODE_W-1:0] s;
		logic [7:0]               b;
		s = $signed(c);
		b = 8'h00;
		if (s <= $signed(CODE_CMD_GEN) && s >= $signed(CODE_CMD_LAST))
			b[ESR_CMD_BIT] = 1'b1; // R11
		else if (s <= $signed(CODE_EXE_GEN) && s >= $signed(CODE_EXE_LAST))
			b[ESR_EXEC_BIT] = 1'b1; // R15
		else if (s <= $signed(CODE_DEV_GEN) && s >= $signed(CODE_DEV_LAST))
			b[ESR_DEV_BIT] = 1'b1; // R17
		else if (s <= $signed(CODE_QRY_GEN) && s >= $signed(CODE_QRY_LAST))
			b[ESR_QUERY_BIT] = 1'b1; // R18
		else if (s > $signed(CODE_NONE))
			b[ESR_DEV_BIT] = 1'b1; // R17
		return b; // R09
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// storage
	queue_if #(.W(CODE_W), .CW(CW)) q ();

	queue_store #(
		.DEPTH (DEPTH),
		.W     (CODE_W)
	) u_store (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.q       (q.store)
	);

	//////////////////////////////////////////////////////////////////////////////
	// bus decode
	bus_state_e         bus_state_reg;
	bus_state_e         bus_state_next;
	logic [DATA_W-1:0]  rdata_reg;
	logic [7:0]         esr_reg;
	logic [7:0]         esr_next;
	logic               tail_mark_reg;
	logic               tail_mark_next;
	logic [CODE_W-1:0]  disp_code_reg;
	logic               disp_show_reg;

	wire                req      = wb_cyc_i & wb_stb_i & (bus_state_reg == BUS_IDLE);
	wire                rd_req   = req & ~wb_we_i;
	wire                wr_req   = req & wb_we_i;
	wire                hit_pop  = (wb_adr_i == OFS_POP);
	wire                hit_lvl  = (wb_adr_i == OFS_LEVEL);
	wire                hit_esr  = (wb_adr_i == OFS_EVENT);
	wire                hit_ctl  = (wb_adr_i == OFS_CONTROL);
	wire                hit_rep  = (wb_adr_i == OFS_REPORT);
	wire                q_empty  = (q.count == '0);
	wire                pop_rd   = rd_req & hit_pop;
	wire                esr_rd   = rd_req & hit_esr;
	wire                clr_cmd  = wr_req & hit_ctl & wb_sel_i[0] & wb_dat_i[CTRL_CLEAR_BIT];
	wire                rep_wr   = wr_req & hit_rep & (&wb_sel_i[1:0]);
	wire [CODE_W-1:0]   rep_code = wb_dat_i[CODE_W-1:0];

	// a read of an empty queue answers zero and leaves the queue as it is
	wire [CODE_W-1:0]   pop_val  = q_empty ? CODE_NONE : q.head; // R06
	wire [DATA_W-1:0]   pop_word = {{(DATA_W-CODE_W){pop_val[CODE_W-1]}}, pop_val}; // R01
	wire [DATA_W-1:0]   lvl_word = {{(DATA_W-LEVEL_MARK_BIT-1){1'b0}}, tail_mark_reg,
	                                {(LEVEL_MARK_BIT-CW){1'b0}}, q.count};
	wire [DATA_W-1:0]   esr_word = {{(DATA_W-8){1'b0}}, esr_reg};
	wire [DATA_W-1:0]   rd_mux;

	assign rd_mux = hit_pop ? pop_word :
	                hit_lvl ? lvl_word :
	                hit_esr ? esr_word : '0;

	always_comb
	begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: if (req) bus_state_next = BUS_ACK;
			BUS_ACK:  bus_state_next = BUS_IDLE;
			default:  bus_state_next = BUS_IDLE;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// error source arbitration
	// one error per cycle; a parser error hides anything else raised with it
	wire                cmd_evt  = hdr_unknown | get_in_msg;
	wire                any_cand;
	wire [CODE_W-1:0]   cand_code;

	assign cand_code = hdr_unknown        ? CODE_HDR_UNDEF : // R13
	                   get_in_msg         ? CODE_GET_MSG   : // R14
	                   exec_param_invalid ? CODE_EXE_GEN   : // R10
	                   selftest_fail      ? CODE_SELFTEST  :
	                   (out_read_empty | out_data_lost) ? CODE_QRY_GEN : // R18
	                   err_valid          ? err_code       :
	                   rep_code;
	// exec_param_invalid is raised by the source after rounding; rounding alone never reaches here
	assign any_cand = cmd_evt | exec_param_invalid | selftest_fail | // R12 R16
	                  out_read_empty | out_data_lost | err_valid | rep_wr;

	// codes outside every class are not recorded
	wire [7:0]          cand_cls = class_bits(cand_code);
	wire                cand_ok  = any_cand & (cand_cls != 8'h00);

	//////////////////////////////////////////////////////////////////////////////
	// occupancy after this cycle's pop or clear
	wire                do_pop   = pop_rd & ~q_empty & ~clr_cmd;
	wire [CW-1:0]       eff_cnt  = clr_cmd ? '0 : (q.count - CW'(do_pop)); // R20
	wire                eff_mark = (eff_cnt != '0) & tail_mark_reg;
	wire                store_ord  = cand_ok & (eff_cnt < ORD_CNT); // R03
	wire                store_mark = cand_ok & (eff_cnt == ORD_CNT) & ~eff_mark; // R04
	wire                do_push  = store_ord | store_mark;
	wire [CODE_W-1:0]   push_code = store_mark ? CODE_OVERFLOW : cand_code; // R04
	wire [7:0]          push_cls = class_bits(push_code);

	assign q.push      = do_push;
	assign q.push_data = push_code;
	assign q.pop       = do_pop; // R01
	assign q.clear     = clr_cmd; // R07

	// once the marker sits at the tail, later errors are dropped until pops bring the count below twenty-nine
	always_comb
	begin
		tail_mark_next = tail_mark_reg;
		if (do_push)
			tail_mark_next = store_mark;
		else if (eff_cnt == '0)
			tail_mark_next = 1'b0; // R07
	end

	// set wins over read-clear and clear command
	always_comb
	begin
		esr_next = esr_reg;
		if (esr_rd | clr_cmd)
			esr_next = ESR_RESET;
		if (do_push)
			esr_next = esr_next | push_cls; // R08
	end

	//////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			bus_state_reg <= BUS_IDLE;
			rdata_reg     <= '0;
			esr_reg       <= ESR_RESET;
			tail_mark_reg <= 1'b0;
		end
		else
		begin
			bus_state_reg <= bus_state_next;
			rdata_reg     <= rd_req ? rd_mux : rdata_reg;
			esr_reg       <= esr_next;
			tail_mark_reg <= tail_mark_next;
		end
	end

	// measurements overwrite the message only when running continuously
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			disp_code_reg <= CODE_NONE;
			disp_show_reg <= 1'b0;
		end
		else
		begin
			disp_code_reg <= do_push ? push_code : disp_code_reg; // R19
			disp_show_reg <= do_push | (disp_show_reg & ~(meas_result_shown & ~single_measurement_setting));
		end
	end

	assign wb_ack_o     = (bus_state_reg == BUS_ACK);
	assign wb_dat_o     = rdata_reg;
	assign disp_code    = disp_code_reg;
	assign disp_show    = disp_show_reg;
	assign event_status = esr_reg;
	assign queue_count  = q.count;

	//////////////////////////////////////////////////////////////////////////////
	// checks
	pop_head_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R01
		(pop_rd & ~q_empty & ~clr_cmd & ~do_push) |=>
		(wb_dat_o[CODE_W-1:0] == $past(q.head)) && (q.count == $past(q.count) - 1'b1))
		else $error("pop did not return and remove the head");

	depth_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R03
		(q.count <= CW'(DEPTH)) && ((q.count == CW'(DEPTH)) -> tail_mark_reg))
		else $error("queue beyond thirty or thirtieth not the marker");

	overflow_mark_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R04
		(cand_ok & ~do_pop & ~clr_cmd & (q.count == ORD_CNT) & ~tail_mark_reg) |=>
		(q.count == CW'(DEPTH)) && tail_mark_reg && (disp_code == CODE_OVERFLOW))
		else $error("overflow marker not written at full queue");

	drop_newest_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R04
		(cand_ok & ~do_pop & ~clr_cmd & (q.count == CW'(DEPTH))) |=> $stable(q.count))
		else $error("error accepted while overflowed");

	empty_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R06
		(pop_rd & q_empty & ~any_cand) |=> (wb_dat_o == '0) && (q.count == '0))
		else $error("empty pop not zero or state changed");

	clear_empty_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R07
		(clr_cmd & ~cand_ok) |=> (q.count == '0) && (event_status == ESR_RESET))
		else $error("clear command did not empty queue");

	cmd_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
		(store_ord & cmd_evt) |=> event_status[ESR_CMD_BIT] && (disp_code == $past(cand_code)))
		else $error("command error did not set bit 5");

	cmd_excl_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
		cmd_evt |-> (cand_cls == (8'h01 << ESR_CMD_BIT)))
		else $error("command event produced another class");

	class_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R08
		do_push |=> ((event_status & $past(push_cls)) == $past(push_cls)))
		else $error("recorded error left its class bit clear");

	display_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R19
		do_push |=> disp_show ##1 (disp_show || $past(meas_result_shown)))
		else $error("display message missing after error");

	same_cycle_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R20
		(do_push & do_pop) |=> $stable(q.count))
		else $error("count wrong on push with pop");

	exec_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
		(store_ord & exec_param_invalid & ~cmd_evt) |=> event_status[ESR_EXEC_BIT])
		else $error("execution error did not set bit 4");

	exec_gen_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
		(store_ord & exec_param_invalid & ~cmd_evt) |=> (disp_code == CODE_EXE_GEN))
		else $error("execution error not recorded as generic code");

	dev_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
		(do_push & ~push_code[CODE_W-1] & (push_code != CODE_NONE)) |=> event_status[ESR_DEV_BIT])
		else $error("positive code did not set bit 3");

	query_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
		(store_ord & (out_read_empty | out_data_lost) & ~cmd_evt & ~exec_param_invalid & ~selftest_fail) |=>
		event_status[ESR_QUERY_BIT] && (disp_code == CODE_QRY_GEN))
		else $error("query error not recorded with bit 2");

	hdr_code_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
		(store_ord & hdr_unknown) |=> (disp_code == CODE_HDR_UNDEF) && event_status[ESR_CMD_BIT])
		else $error("unknown header not recorded as command error");

	trig_code_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
		(store_ord & get_in_msg & ~hdr_unknown) |=> (disp_code == CODE_GET_MSG))
		else $error("trigger in message not recorded");

	last_pop_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R07
		(do_pop & ~do_push & (q.count == CW'(1))) |=> (q.count == '0) && ~tail_mark_reg)
		else $error("last pop did not empty the queue");

	empty_mark_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R07
		(q.count == '0) |-> ~tail_mark_reg)
		else $error("marker flag set on empty queue");

	drop_unknown_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R09
		(any_cand & (cand_cls == 8'h00) & ~do_pop & ~clr_cmd) |=> $stable(q.count))
		else $error("unclassified code was stored");

	mark_full_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R20
		(do_push & do_pop & (q.count == ORD_CNT) & ~tail_mark_reg) |=> ~tail_mark_reg)
		else $error("marker written while a slot was freed");

	read_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R08
		(esr_rd & do_push) |=> (event_status == $past(push_cls)))
		else $error("class bit lost to status read");

	err_code_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R19
		(store_ord & err_valid & ~cmd_evt & ~exec_param_invalid & ~selftest_fail & ~out_read_empty &
		~out_data_lost) |=> (disp_code == $past(err_code)) && disp_show)
		else $error("reported code not shown");

	empty_esr_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R06
		(pop_rd & q_empty & ~any_cand) |=> $stable(event_status))
		else $error("empty pop changed event status");
endmodule

// >>> wb_host_model.sv
`timescale 1ns/100ps
module wb_host_model
(
	// clock
	input  wire logic                               ref_clk,
	// bus towards the queue
	output logic                                    wb_cyc_o,
	output logic                                    wb_stb_o,
	output logic                                    wb_we_o,
	output logic      [error_queue_pkg::ADR_W-1:0]  wb_adr_o,
	output logic      [3:0]                         wb_sel_o,
	output logic      [error_queue_pkg::DATA_W-1:0] wb_dat_o,
	input  wire logic                               wb_ack_i,
	input  wire logic [error_queue_pkg::DATA_W-1:0] wb_dat_i
);
	import error_queue_pkg::*;

	initial
	begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h00000000;
	end

	//////////////////////////////////////////////////////////////////////////////
	// one classic cycle; the bound only guards against a dead slave
	task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] q, output bit ok);
		int n;
		n = 0;
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hF;
		wb_dat_o <= dat;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (wb_ack_i !== 1'b1 && n < 40);
		ok = (wb_ack_i === 1'b1);
		q  = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= 1'b0;
		// released lines must not keep looking valid
		wb_adr_o <= ~adr;
		wb_dat_o <= ~dat;
		@(posedge ref_clk);
	endtask
endmodule

// >>> tb_error_code_queue.sv
`timescale 1ns/100ps
module tb_error_code_queue;
	import error_queue_pkg::*;

	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic [6:0]  src = 7'h00;
	logic [15:0] err_code = 16'h0000;
	logic        single_measurement_setting = 1'b0;
	logic        meas_result_shown = 1'b0;
	logic [15:0] disp_code;
	logic        disp_show;
	logic [7:0]  event_status;
	logic [4:0]  queue_count;
	int          err_total = 0;
	int          checks = 0;
	logic [15:0] mq [$];
	bit          mark = 1'b0;
	// source mask, code, expected event status
	logic [30:0] tab [18] = '{
		{7'h01, CODE_HDR_UNDEF, 8'h20}, {7'h02, CODE_GET_MSG, 8'h20}, {7'h04, CODE_EXE_GEN, 8'h10},
		{7'h08, CODE_SELFTEST, 8'h08}, {7'h10, CODE_QRY_GEN, 8'h04}, {7'h20, CODE_QRY_GEN, 8'h04},
		{7'h40, CODE_CMD_GEN, 8'h20}, {7'h40, CODE_CMD_LAST, 8'h20}, {7'h40, CODE_EXE_GEN, 8'h10},
		{7'h40, CODE_EXE_LAST, 8'h10}, {7'h40, CODE_DEV_GEN, 8'h08}, {7'h40, CODE_DEV_LAST, 8'h08},
		{7'h40, CODE_QRY_GEN, 8'h04}, {7'h40, CODE_QRY_LAST, 8'h04}, {7'h40, 16'h0001, 8'h08},
		{7'h40, CODE_POS_LAST, 8'h08}, {7'h40, 16'hFF9D, 8'h00}, {7'h40, 16'hFE0C, 8'h00}
	};

	always #5 ref_clk = ~ref_clk;

	error_code_queue error_code_queue_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .err_valid(src[6]), .err_code(err_code),
		.hdr_unknown(src[0]), .get_in_msg(src[1]), .exec_param_invalid(src[2]), .selftest_fail(src[3]),
		.out_read_empty(src[4]), .out_data_lost(src[5]),
		.single_measurement_setting(single_measurement_setting), .meas_result_shown(meas_result_shown),
		.disp_code(disp_code), .disp_show(disp_show), .event_status(event_status),
		.queue_count(queue_count));

	wb_host_model wb_host_model_i (.ref_clk(ref_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
		.wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
		.wb_ack_i(wb_ack), .wb_dat_i(wb_rdat));

	//////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		bit ok;
		wb_host_model_i.access(we, a, d, q, ok);
		if (!ok)
		begin
			err_total++;
			$display("[FAIL] ack expected 1 seen 0");
			conclude();
		end
	endtask

	// the error lines are sampled at one edge; the second edge lets the result land
	task automatic fire(input logic [6:0] s, input logic [15:0] c, input bit rec);
		src <= s;
		err_code <= c;
		@(posedge ref_clk);
		src <= 7'h00;
		@(posedge ref_clk);
		if (rec && !mark && mq.size() < ORD_SLOTS)
			mq.push_back(c);
		else if (rec && !mark)
		begin
			mq.push_back(CODE_OVERFLOW);
			mark = 1'b1;
		end
	endtask

	task automatic pop_exp();
		logic [15:0] c;
		logic [31:0] q;
		c = (mq.size() > 0) ? mq.pop_front() : CODE_NONE;
		if (mq.size() == 0)
			mark = 1'b0;
		bus(1'b0, OFS_POP, 32'h00000000, q);
		chk_word("pop", {{16{c[15]}}, c}, q);
	endtask

	task automatic chk_state(input logic [4:0] n, input logic [7:0] e);
		chk_word("count", {27'h0000000, n}, {27'h0000000, queue_count});
		chk_word("event_status", {24'h000000, e}, {24'h000000, event_status});
	endtask

	task automatic meas();
		meas_result_shown <= 1'b1;
		@(posedge ref_clk);
		meas_result_shown <= 1'b0;
		@(posedge ref_clk);
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		$display("[FAIL] run expected done seen hang");
		conclude();
	end

	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] q;
		logic [30:0] t;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		chk_state(5'h00, 8'h00);
		pop_exp();
		chk_state(5'h00, 8'h00);
		for (int i = 0; i < 18; i++)
		begin
			t = tab[i];
			fire(t[30:24], t[23:8], t[7:0] != 8'h00);
			chk_word("event_status", {24'h000000, t[7:0]}, {24'h000000, event_status});
			bus(1'b0, OFS_EVENT, 32'h00000000, q);
			chk_word("event", {24'h000000, t[7:0]}, q);
			if (t[7:0] != 8'h00)
				chk_word("display", {16'h0001, t[23:8]}, {15'h0000, disp_show, disp_code});
		end
		chk_state(5'h10, 8'h00);
		while (mq.size() > 0)
			pop_exp();
		chk_state(5'h00, 8'h00);
		pop_exp();
		fire(7'h05, CODE_HDR_UNDEF, 1'b1);
		chk_state(5'h01, 8'h20);
		pop_exp();
		bus(1'b0, OFS_EVENT, 32'h00000000, q);
		for (int i = 1; i <= 29; i++)
			fire(7'h40, 16'(i), 1'b1);
		bus(1'b0, OFS_LEVEL, 32'h00000000, q);
		chk_word("level", 32'h0000001D, q);
		pop_exp();
		for (int i = 30; i <= 32; i++)
			fire(7'h40, 16'(i), 1'b1);
		bus(1'b0, OFS_LEVEL, 32'h00000000, q);
		chk_word("level", 32'h0000011E, q);
		pop_exp();
		fire(7'h40, 16'h0021, 1'b1);
		chk_word("count", 32'h0000001D, {27'h0000000, queue_count});
		while (mq.size() > 0)
			pop_exp();
		pop_exp();
		fire(7'h04, CODE_EXE_GEN, 1'b1);
		bus(1'b1, OFS_CONTROL, 32'h00000001, q);
		mq.delete();
		chk_state(5'h00, 8'h00);
		pop_exp();
		fire(7'h40, 16'h0007, 1'b1);
		fork
			bus(1'b0, OFS_POP, 32'h00000000, q);
			fire(7'h40, 16'h0008, 1'b1);
		join
		void'(mq.pop_front());
		chk_word("pop", 32'h00000007, q);
		chk_word("count", 32'h00000001, {27'h0000000, queue_count});
		pop_exp();
		bus(1'b0, OFS_EVENT, 32'h00000000, q);
		bus(1'b1, OFS_REPORT, {16'h0000, CODE_QRY_GEN}, q);
		mq.push_back(CODE_QRY_GEN);
		bus(1'b1, 8'h20, 32'h00000001, q);
		bus(1'b0, 8'h20, 32'h00000000, q);
		chk_word("unmapped", 32'h00000000, q);
		chk_state(5'h01, 8'h04);
		pop_exp();
		single_measurement_setting <= 1'b1;
		fire(7'h08, CODE_SELFTEST, 1'b1);
		meas();
		chk_word("display", {16'h0001, CODE_SELFTEST}, {15'h0000, disp_show, disp_code});
		single_measurement_setting <= 1'b0;
		meas();
		chk_word("shown", 32'h00000000, {31'h00000000, disp_show});
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		mq.delete();
		chk_state(5'h00, 8'h00);
		pop_exp();
		conclude();
	end
endmodule
